// >>> hdl/cmr_core_regs.sv
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_core_regs
  import cmr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  // Reset vector fetch
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Pipeline
  input wire logic pipe_adv,
  output logic [31:0] ifetch_addr,
  output logic ifetch_valid,
  output logic [31:0] exec_pc,
  output logic exec_valid,
  output logic core_ready,
  // Core register file
  input wire cmr_rf_req_t rf_req,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  output logic rf_illegal,
  // Condition flags from the ALU
  input wire logic flag_we,
  input wire logic [3:0] flag_in,
  // Subroutine call link value
  input wire logic call_en,
  input wire logic [31:0] call_link,
  // Special register moves
  input wire cmr_sr_req_t sr_req,
  output logic [31:0] sr_rd_data,
  // Exceptions
  input wire cmr_exc_t exc,
  output logic exc_take,
  output logic hard_fault,
  output logic handler_mode,
  output logic psp_active,
  // Multiplier
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  output logic [31:0] mul_result,
  // Address decode
  input wire logic [31:0] dec_addr,
  input wire logic dec_fetch,
  output cmr_region_t dec_region,
  output logic dec_bus_fault,
  output logic dec_exec_fault
);

  cmr_state_t st;
  cmr_state_t next_st;

  // Valid exception numbers
  function automatic logic exc_num_ok(input logic [5:0] n);
    exc_num_ok = (n == `CMR_EXC_NMI) || (n == `CMR_EXC_HARD_FAULT_A) ||
                 (n == `CMR_EXC_SVC) || (n == `CMR_EXC_PENDABLE_SERVICE) ||
                 (n == `CMR_EXC_SYSTEM_TICK_TIMER) ||
                 ((n >= `CMR_EXC_IRQ_FIRST) && (n <= `CMR_EXC_IRQ_LAST));
  endfunction

  // Currently selected stack pointer
  function automatic logic use_psp(input cmr_state_t s);
    use_psp = (s.active_exc == `CMR_EXC_THREAD) && s.sp_sel;
  endfunction

  // Architectural register read
  function automatic logic [31:0] read_reg(input cmr_state_t s, input logic [3:0] idx);
    if (idx == `CMR_REG_PC) begin
      read_reg = s.pc_execute + `CMR_PC_READ_OFS;
    end else if (idx == `CMR_REG_LR) begin
      read_reg = s.link;
    end else if (idx == `CMR_REG_SP) begin
      read_reg = use_psp(s) ? s.proc_sp : s.main_sp;
    end else begin
      read_reg = s.gpr[idx];
    end
  endfunction

  // Combined status image
  function automatic logic [31:0] combined(input cmr_state_t s);
    combined = 32'h00000000;
    combined[`CMR_FLAG_LSB +: 4] = s.flags;
    combined[`CMR_TBIT_POS] = s.tbit;
    combined[5:0] = s.active_exc;
  endfunction

  // Special register read image; reserved bits read as zero
  function automatic logic [31:0] sr_image(input cmr_state_t s, input cmr_sr_sel_t sel);
    case (sel)
      CMR_SR_COMBINED: sr_image = combined(s);
      CMR_SR_FLAGS: sr_image = {s.flags, 28'h0000000};
      CMR_SR_EXEC: sr_image = {7'h00, s.tbit, 24'h000000};
      CMR_SR_ACTIVE: sr_image = {26'h0000000, s.active_exc};
      CMR_SR_MAIN_SP: sr_image = s.main_sp;
      CMR_SR_PROC_SP: sr_image = s.proc_sp;
      CMR_SR_MASK: sr_image = {31'h00000000, s.exc_mask};
      CMR_SR_CONTROL: sr_image = {30'h00000000, s.sp_sel, 1'b0};
      default: sr_image = 32'h00000000;
    endcase
  endfunction

  // Address range test, both bounds inclusive
  function automatic logic in_span(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  // Region of an address; gaps between the named ranges count as unused
  function automatic cmr_region_t region_of(input logic [31:0] a);
    if (in_span(a, `CMR_CODE_LO, `CMR_CODE_HI)) begin
      region_of = CMR_REG_CODE;
    end else if (in_span(a, `CMR_SRAM_LO, `CMR_SRAM_HI)) begin
      region_of = CMR_REG_SRAM;
    end else if (in_span(a, `CMR_PERI_LO, `CMR_PERI_HI)) begin
      region_of = CMR_REG_PERI;
    end else if (in_span(a, `CMR_PRIV_LO, `CMR_PRIV_HI)) begin
      region_of = CMR_REG_PRIV;
    end else if (a > `CMR_PRIV_HI) begin
      region_of = CMR_REG_VENDOR;
    end else begin
      region_of = CMR_REG_UNUSED;
    end
  endfunction

  // Code, data memory and unused addresses may hold instructions
  function automatic logic fetch_refused(input cmr_region_t r);
    case (r)
      CMR_REG_CODE, CMR_REG_SRAM: fetch_refused = 1'b0;
      CMR_REG_UNUSED: fetch_refused = 1'b0;
      default: fetch_refused = 1'b1;
    endcase
  endfunction

  // Link value on exception entry; bit 2 records the stack in use
  function automatic logic [31:0] entry_link(input cmr_state_t s);
    entry_link = `CMR_EXC_RETURN_BASE;
    entry_link[`CMR_EXC_RET_PSP_BIT] = use_psp(s);
  endfunction

  logic running;
  logic narrow_bad;
  logic rf_wr_ok;
  logic pc_wr;
  logic exc_allowed;
  logic [63:0] product;

  assign running = (st.boot == CMR_RUN);

  // Narrow encodings may not touch r8 and up
  assign narrow_bad = rf_req.narrow && ((rf_req.rd_a_idx > `CMR_LOW_REG_LAST) ||
                      (rf_req.rd_b_idx > `CMR_LOW_REG_LAST) ||
                      (rf_req.wr_en && (rf_req.wr_idx > `CMR_LOW_REG_LAST)));
  assign rf_wr_ok = running && rf_req.wr_en && !narrow_bad;
  assign pc_wr = rf_wr_ok && (rf_req.wr_idx == `CMR_REG_PC);

  // Mask gates everything but non-maskable interrupt and hard fault
  assign exc_allowed = !st.exc_mask || (exc.num == `CMR_EXC_NMI) ||
                       (exc.num == `CMR_EXC_HARD_FAULT_A);
  assign exc_take = running && exc.req && exc_num_ok(exc.num) && exc_allowed;

  assign product = mul_a * mul_b;

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.hard_fault = 1'b0;
    next_st.rf_illegal = 1'b0;
    next_st.mul_res = product[31:0];

    // Address decode, one cycle latency, live even during the vector fetch
    next_st.region = region_of(dec_addr);
    next_st.bus_fault = (next_st.region == CMR_REG_UNUSED);
    next_st.exec_fault = dec_fetch && fetch_refused(next_st.region);

    case (st.boot)
      CMR_BOOT_SP: begin
        if (mem_ack) begin
          next_st.main_sp = mem_rdata;
          next_st.boot = CMR_BOOT_PC;
        end
      end
      CMR_BOOT_PC: begin
        if (mem_ack) begin
          next_st.pc_fetch = mem_rdata & `CMR_ADDR_LSB_CLR;
          next_st.tbit = mem_rdata[0];
          next_st.v_decode = 1'b0;
          next_st.v_execute = 1'b0;
          next_st.boot = CMR_RUN;
        end
      end
      CMR_RUN: begin
        // Operand reads
        next_st.rd_a = read_reg(st, rf_req.rd_a_idx);
        next_st.rd_b = read_reg(st, rf_req.rd_b_idx);
        next_st.rf_illegal = narrow_bad;

        // Special register reads show the state before this cycle's writes
        next_st.sr_rd = sr_image(st, sr_req.sel);

        // Instruction flag results
        if (flag_we) begin
          next_st.flags = flag_in;
        end

        // Special register writes; execution state and active number are read-only
        if (sr_req.wr_en) begin
          case (sr_req.sel)
            CMR_SR_COMBINED, CMR_SR_FLAGS: begin
              next_st.flags = sr_req.wr_data[`CMR_FLAG_LSB +: 4];
            end
            CMR_SR_MAIN_SP: next_st.main_sp = sr_req.wr_data;
            CMR_SR_PROC_SP: next_st.proc_sp = sr_req.wr_data;
            CMR_SR_MASK: next_st.exc_mask = sr_req.wr_data[`CMR_PMASK_BIT];
            CMR_SR_CONTROL: begin
              if (st.active_exc == `CMR_EXC_THREAD) begin
                next_st.sp_sel = sr_req.wr_data[`CMR_CTRL_SPSEL_BIT];
              end
            end
            default: next_st.sp_sel = st.sp_sel;
          endcase
        end

        // Call link
        if (call_en) begin
          next_st.link = call_link;
        end

        // General register writes
        if (rf_wr_ok) begin
          if (rf_req.wr_idx == `CMR_REG_LR) begin
            next_st.link = rf_req.wr_data;
          end else if (rf_req.wr_idx == `CMR_REG_SP) begin
            if (use_psp(st)) begin
              next_st.proc_sp = rf_req.wr_data;
            end else begin
              next_st.main_sp = rf_req.wr_data;
            end
          end else if (rf_req.wr_idx != `CMR_REG_PC) begin
            next_st.gpr[rf_req.wr_idx] = rf_req.wr_data;
          end
        end

        // Pipeline advance: fetch, decode, execute
        // A cleared execution-state bit faults as soon as a decoded slot moves on
        if (pipe_adv) begin
          next_st.pc_decode = st.pc_fetch;
          next_st.pc_execute = st.pc_decode;
          next_st.v_decode = 1'b1;
          next_st.v_execute = st.v_decode;
          next_st.pc_fetch = st.pc_fetch + `CMR_INSTR_STEP;
          next_st.hard_fault = st.v_decode && !st.tbit;
        end

        // Redirects flush the pipeline; exception entry wins
        // Entry, return and a program counter write never combine in one cycle
        if (exc_take) begin
          next_st.link = entry_link(st);
          next_st.active_exc = exc.num;
          next_st.sp_sel = 1'b0;
          next_st.pc_fetch = exc.target & `CMR_ADDR_LSB_CLR;
          next_st.v_decode = 1'b0;
          next_st.v_execute = 1'b0;
        end else if (exc.ret) begin
          next_st.active_exc = exc.ret_num;
          next_st.sp_sel = exc.ret_psp && (exc.ret_num == `CMR_EXC_THREAD);
          next_st.pc_fetch = exc.ret_pc & `CMR_ADDR_LSB_CLR;
          next_st.v_decode = 1'b0;
          next_st.v_execute = 1'b0;
        end else if (pc_wr) begin
          next_st.pc_fetch = rf_req.wr_data & `CMR_ADDR_LSB_CLR;
          next_st.v_decode = 1'b0;
          next_st.v_execute = 1'b0;
        end
      end
      default: next_st.boot = CMR_BOOT_SP;
    endcase
  end

  // State register
  // Link, stacks and general registers reset to zero here, though software
  // may not rely on it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.boot <= CMR_BOOT_SP;
      st.sp_sel <= 1'b0;
      st.active_exc <= `CMR_EXC_THREAD;
      st.exc_mask <= 1'b0;
      st.region <= CMR_REG_CODE;
    end else begin
      st <= next_st;
    end
  end

  // Vector fetch port
  assign mem_req = !running;
  assign mem_addr = (st.boot == CMR_BOOT_SP) ? `CMR_VEC_SP_ADDR : `CMR_VEC_PC_ADDR;

  // Outputs
  assign core_ready = running;
  assign ifetch_addr = st.pc_fetch;
  assign ifetch_valid = running;
  assign exec_pc = st.pc_execute;
  assign exec_valid = st.v_execute;
  assign rd_a_data = st.rd_a;
  assign rd_b_data = st.rd_b;
  assign rf_illegal = st.rf_illegal;
  assign sr_rd_data = st.sr_rd;
  assign hard_fault = st.hard_fault;
  assign handler_mode = (st.active_exc != `CMR_EXC_THREAD);
  assign psp_active = use_psp(st);
  assign mul_result = st.mul_res;
  assign dec_region = st.region;
  assign dec_bus_fault = st.bus_fault;
  assign dec_exec_fault = st.exec_fault;

endmodule

// >>> hdl/cmr_params.svh
`ifndef CMR_PARAMS_SVH
`define CMR_PARAMS_SVH

// Address map boundaries
`define CMR_CODE_LO 32'h00000000
`define CMR_CODE_HI 32'h1FFFFFF
`define CMR_SRAM_LO 32'h20000000
`define CMR_SRAM_HI 32'h3FFFFFFF
`define CMR_PERI_LO 32'h40000000
`define CMR_PERI_HI 32'h5FFFFFFF
`define CMR_UNUSED_LO 32'h60000000
`define CMR_UNUSED_HI 32'hDFFFFFFF
`define CMR_PRIV_LO 32'hE0000000
`define CMR_PRIV_HI 32'hE00FFFFF

// Reset vector words
`define CMR_VEC_SP_ADDR 32'h00000000
`define CMR_VEC_PC_ADDR 32'h00000004

// Program counter handling
`define CMR_INSTR_STEP 32'h00000002
`define CMR_PC_READ_OFS 32'h00000004
`define CMR_ADDR_LSB_CLR 32'hFFFFFFFE

// Link value written on exception entry
`define CMR_EXC_RETURN_BASE 32'hFFFFFFF9
`define CMR_EXC_RET_PSP_BIT 2

// Status register layout
`define CMR_FLAG_LSB 28
`define CMR_TBIT_POS 24
`define CMR_CTRL_SPSEL_BIT 1
`define CMR_PMASK_BIT 0

// Register indices
`define CMR_N_GPR 13
`define CMR_REG_SP 4'hD
`define CMR_REG_LR 4'hE
`define CMR_REG_PC 4'hF
`define CMR_LOW_REG_LAST 4'h7

// Exception numbers
`define CMR_EXC_THREAD 6'h00
`define CMR_EXC_NMI 6'h02
`define CMR_EXC_HARD_FAULT_A 6'h03
`define CMR_EXC_SVC 6'h0B
`define CMR_EXC_PENDABLE_SERVICE 6'h0E
`define CMR_EXC_SYSTEM_TICK_TIMER 6'h0F
`define CMR_EXC_IRQ_FIRST 6'h10
`define CMR_EXC_IRQ_LAST 6'h2F

`endif

// >>> hdl/cmr_pkg.sv
package cmr_pkg;

  typedef enum {CMR_BOOT_SP, CMR_BOOT_PC, CMR_RUN} cmr_boot_t;

  typedef enum logic [2:0] {
    CMR_REG_CODE, CMR_REG_SRAM, CMR_REG_PERI, CMR_REG_UNUSED, CMR_REG_PRIV, CMR_REG_VENDOR
  } cmr_region_t;

  typedef enum logic [2:0] {
    CMR_SR_COMBINED, CMR_SR_FLAGS, CMR_SR_EXEC, CMR_SR_ACTIVE,
    CMR_SR_MAIN_SP, CMR_SR_PROC_SP, CMR_SR_MASK, CMR_SR_CONTROL
  } cmr_sr_sel_t;

  // Core register file access from the execute stage
  typedef struct packed {
    logic [3:0] rd_a_idx;
    logic [3:0] rd_b_idx;
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
    logic narrow;
  } cmr_rf_req_t;

  // Special register move
  typedef struct packed {
    cmr_sr_sel_t sel;
    logic wr_en;
    logic [31:0] wr_data;
  } cmr_sr_req_t;

  // Exception entry and return
  typedef struct packed {
    logic req;
    logic [5:0] num;
    logic [31:0] target;
    logic ret;
    logic [5:0] ret_num;
    logic ret_psp;
    logic [31:0] ret_pc;
  } cmr_exc_t;

  typedef struct packed {
    cmr_boot_t boot;
    logic [12:0][31:0] gpr;
    logic [31:0] main_sp;
    logic [31:0] proc_sp;
    logic [31:0] link;
    logic [31:0] pc_fetch;
    logic [31:0] pc_decode;
    logic [31:0] pc_execute;
    logic v_decode;
    logic v_execute;
    logic [3:0] flags;
    logic tbit;
    logic [5:0] active_exc;
    logic exc_mask;
    logic sp_sel;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [31:0] sr_rd;
    logic [31:0] mul_res;
    cmr_region_t region;
    logic bus_fault;
    logic exec_fault;
    logic hard_fault;
    logic rf_illegal;
  } cmr_state_t;

endpackage

// >>> tb/cmr_core_regs_chk.sv
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_core_regs_chk
  import cmr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic core_ready,
  input wire cmr_rf_req_t rf_req,
  input wire logic rf_illegal,
  input wire cmr_exc_t exc,
  input wire logic exc_take,
  input wire logic handler_mode,
  input wire logic psp_active,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  input wire logic [31:0] mul_result,
  input wire logic [31:0] dec_addr,
  input wire logic dec_fetch,
  input wire cmr_region_t dec_region,
  input wire logic dec_bus_fault,
  input wire logic dec_exec_fault
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Steps of the reset vector fetch
  sequence s_sp_taken;
    mem_req && mem_addr == `CMR_VEC_SP_ADDR && mem_ack;
  endsequence
  sequence s_pc_taken;
    mem_req && mem_addr == `CMR_VEC_PC_ADDR && mem_ack;
  endsequence

  a_sp_then_pc: assert property (s_sp_taken |=> mem_req && mem_addr == `CMR_VEC_PC_ADDR)
    else $error("stack word fetch did not move on");
  a_ready_after_pc: assert property (s_pc_taken |=> core_ready && !mem_req)
    else $error("core not ready after pc word");
  a_narrow_refused: assert property (core_ready && rf_req.narrow && rf_req.wr_en
    && rf_req.wr_idx > `CMR_LOW_REG_LAST |=> rf_illegal)
    else $error("narrow high write not refused");
  a_mul_single: assert property (core_ready |=> mul_result == $past(mul_a) * $past(mul_b))
    else $error("multiply result wrong");
  a_code_region: assert property (dec_addr <= `CMR_CODE_HI
    |=> dec_region == CMR_REG_CODE && !dec_bus_fault && !dec_exec_fault)
    else $error("code region decode wrong");
  a_sram_fetch_ok: assert property (dec_fetch && dec_addr inside {[`CMR_SRAM_LO:`CMR_SRAM_HI]}
    |=> dec_region == CMR_REG_SRAM && !dec_exec_fault)
    else $error("data region fetch refused");
  a_peri_no_fetch: assert property (dec_fetch && dec_addr inside {[`CMR_PERI_LO:`CMR_PERI_HI]}
    |=> dec_region == CMR_REG_PERI && dec_exec_fault)
    else $error("peripheral fetch not refused");
  a_priv_region: assert property (dec_addr inside {[`CMR_PRIV_LO:`CMR_PRIV_HI]}
    |=> dec_region == CMR_REG_PRIV)
    else $error("private range decode wrong");
  a_unused_fault: assert property (dec_addr inside {[`CMR_UNUSED_LO:`CMR_UNUSED_HI]}
    |=> dec_bus_fault)
    else $error("unused range gave no bus fault");
  a_entry_main_sp: assert property (exc_take |=> handler_mode && !psp_active)
    else $error("handler not on main stack");
  a_exc_num_valid: assert property (exc_take |-> exc.num inside {2, 3, 11, 14, 15, [16:47]})
    else $error("invalid exception number taken");
endmodule

bind cmr_core_regs cmr_core_regs_chk u_chk (.*);

// >>> tb/cmr_mem_model.sv
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_mem_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic [31:0] sp_word,
  input wire logic [31:0] pc_word,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic [31:0] mem_rdata = 32'h5A5A5A5A,
  output logic mem_ack = 1'b0
);
  logic [1:0] stall = 2'h0;

  // Vector word responder; data line toggles when no word is on it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      stall <= 2'h0;
    end else if (mem_req && !mem_ack && (!slow || stall == 2'h3)) begin
      mem_ack <= 1'b1;
      mem_rdata <= (mem_addr == `CMR_VEC_PC_ADDR) ? pc_word : sp_word;
      stall <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      stall <= stall + 2'h1;
    end
  end
endmodule

// >>> tb/test_cmr_core_regs.sv
`timescale 1ns/1ps
`include "cmr_params.svh"

module test_cmr_core_regs
  import cmr_pkg::*;
;
  localparam logic [31:0] SP_W = 32'h20000800;
  logic core_clk = 1'b0;
  logic resetn;
  logic mem_req, mem_ack, rf_illegal, ifetch_valid, exec_valid, core_ready;
  logic exc_take, hard_fault, handler_mode, psp_active, dec_bus_fault, dec_exec_fault;
  logic [31:0] mem_addr, mem_rdata, ifetch_addr, exec_pc, rd_a_data, rd_b_data;
  logic [31:0] sr_rd_data, mul_result;
  logic pipe_adv = 1'b0, flag_we = 1'b0, call_en = 1'b0, dec_fetch = 1'b0, slow = 1'b0;
  logic [3:0] flag_in = 4'h0;
  logic [31:0] call_link = 32'h0, mul_a = 32'h0, mul_b = 32'h0, dec_addr = 32'h0;
  logic [31:0] sp_word = SP_W, pc_word = 32'h0;
  cmr_rf_req_t rf_req = '0;
  cmr_sr_req_t sr_req = '0;
  cmr_exc_t exc = '0;
  cmr_region_t dec_region;
  int miscompares = 0, tests_run = 0, cycles = 0;

  cmr_core_regs u_dut (.*);
  cmr_mem_model u_mem (.*);

  // Free-running core clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic boot(input logic [31:0] pc, input logic sl);
    resetn = 1'b0;
    pc_word = pc;
    slow = sl;
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 40 && core_ready !== 1'b1; i++) tick();
  endtask

  task automatic rf_wr(input logic [3:0] idx, input logic [31:0] d, input logic nar);
    tick();
    rf_req = '{4'h0, 4'h0, 1'b1, idx, d, nar};
    tick();
    rf_req = '0;
  endtask

  task automatic rf_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
    tick();
    rf_req = '{idx, idx, 1'b0, 4'h0, 32'h0, 1'b0};
    tick();
    check(what, rd_a_data, exp);
    check(what, rd_b_data, exp);
  endtask

  task automatic sr_wr(input cmr_sr_sel_t sel, input logic [31:0] d);
    tick();
    sr_req = '{sel, 1'b1, d};
    tick();
    sr_req.wr_en = 1'b0;
  endtask

  task automatic sr_chk(input string what, input cmr_sr_sel_t sel, input logic [31:0] exp);
    tick();
    sr_req = '{sel, 1'b0, 32'h0};
    tick();
    check(what, sr_rd_data, exp);
  endtask

  task automatic dec_chk(input logic [31:0] a, input logic f, input cmr_region_t r,
                         input logic bf, input logic ef);
    tick();
    dec_addr = a;
    dec_fetch = f;
    tick();
    check("region", 32'(dec_region), 32'(r));
    check("faults", {30'h0, dec_bus_fault, dec_exec_fault}, {30'h0, bf, ef});
  endtask

  task automatic exc_try(input logic [5:0] num, input logic take);
    tick();
    exc = '{1'b1, num, 32'h00000201, 1'b0, 6'h00, 1'b0, 32'h0};
    #1;
    check("exc take", 32'(exc_take), 32'(take));
  endtask

  // Main sequence
  initial begin
    boot(32'h00000101, 1'b0);
    check("boot pc", ifetch_addr, 32'h00000100);
    check("fetch valid", 32'(ifetch_valid), 32'h1);
    check("vec req", 32'(mem_req), 32'h0);
    sr_chk("exec", CMR_SR_EXEC, 32'h01000000);
    sr_chk("boot sp", CMR_SR_MAIN_SP, SP_W);
    sr_chk("control", CMR_SR_CONTROL, 32'h0);
    sr_chk("mask", CMR_SR_MASK, 32'h0);
    sr_chk("active", CMR_SR_ACTIVE, 32'h0);
    sr_chk("combined", CMR_SR_COMBINED, 32'h01000000);
    for (int i = 0; i < `CMR_N_GPR; i++) rf_wr(i[3:0], 32'hC0DE0000 + i, 1'b0);
    for (int i = 0; i < `CMR_N_GPR; i++) rf_chk("gpr", i[3:0], 32'hC0DE0000 + i);
    rf_wr(4'h9, 32'hBAD0BAD0, 1'b1);
    check("illegal", 32'(rf_illegal), 32'h1);
    rf_chk("dropped", 4'h9, 32'hC0DE0009);
    rf_wr(4'hD, 32'h20001000, 1'b0);
    sr_wr(CMR_SR_CONTROL, 32'h00000002);
    check("psp on", 32'(psp_active), 32'h1);
    rf_wr(4'hD, 32'h20002000, 1'b0);
    sr_chk("psp", CMR_SR_PROC_SP, 32'h20002000);
    sr_chk("msp", CMR_SR_MAIN_SP, 32'h20001000);
    sr_wr(CMR_SR_FLAGS, 32'hA0000000);
    sr_wr(CMR_SR_ACTIVE, 32'h0000000B);
    sr_chk("combined", CMR_SR_COMBINED, 32'hA1000000);
    tick();
    flag_we = 1'b1;
    flag_in = 4'h5;
    tick();
    flag_we = 1'b0;
    sr_chk("alu flags", CMR_SR_FLAGS, 32'h50000000);
    tick();
    call_en = 1'b1;
    call_link = 32'h00000123;
    tick();
    call_en = 1'b0;
    rf_chk("call link", 4'hE, 32'h00000123);
    mul_a = 32'hFFFFFFFF;
    mul_b = 32'hFFFFFFFF;
    tick();
    check("mul", mul_result, 32'h00000001);
    dec_chk(32'h01FFFFFF, 1'b1, CMR_REG_CODE, 1'b0, 1'b0);
    dec_chk(32'h20000000, 1'b1, CMR_REG_SRAM, 1'b0, 1'b0);
    dec_chk(32'h3FFFFFFF, 1'b1, CMR_REG_SRAM, 1'b0, 1'b0);
    dec_chk(32'h40000000, 1'b1, CMR_REG_PERI, 1'b0, 1'b1);
    dec_chk(32'h5FFFFFFF, 1'b0, CMR_REG_PERI, 1'b0, 1'b0);
    dec_chk(32'h60000000, 1'b0, CMR_REG_UNUSED, 1'b1, 1'b0);
    dec_chk(32'hDFFFFFFF, 1'b0, CMR_REG_UNUSED, 1'b1, 1'b0);
    dec_chk(32'hE00FFFFF, 1'b0, CMR_REG_PRIV, 1'b0, 1'b0);
    rf_wr(4'hF, 32'h20000101, 1'b0);
    check("redirect", ifetch_addr, 32'h20000100);
    check("flushed", 32'(exec_valid), 32'h0);
    pipe_adv = 1'b1;
    tick();
    tick();
    pipe_adv = 1'b0;
    check("exec pc", exec_pc, 32'h20000100);
    check("exec valid", 32'(exec_valid), 32'h1);
    check("fetch step", ifetch_addr, 32'h20000104);
    check("no fault", 32'(hard_fault), 32'h0);
    rf_chk("pc read", 4'hF, 32'h20000104);
    sr_wr(CMR_SR_MASK, 32'h00000001);
    exc_try(`CMR_EXC_IRQ_FIRST, 1'b0);
    exc_try(6'h05, 1'b0);
    exc_try(`CMR_EXC_HARD_FAULT_A, 1'b1);
    tick();
    exc.req = 1'b0;
    check("handler", 32'(handler_mode), 32'h1);
    check("vector", ifetch_addr, 32'h00000200);
    rf_chk("exc link", 4'hE, 32'hFFFFFFFD);
    sr_chk("exc number", CMR_SR_ACTIVE, 32'h00000003);
    sr_wr(CMR_SR_CONTROL, 32'h00000002);
    check("ctrl ignored", 32'(psp_active), 32'h0);
    tick();
    exc = '{1'b0, 6'h00, 32'h0, 1'b1, 6'h00, 1'b1, 32'h00000301};
    tick();
    exc.ret = 1'b0;
    check("ret thread", 32'(handler_mode), 32'h0);
    check("ret psp", 32'(psp_active), 32'h1);
    check("ret pc", ifetch_addr, 32'h00000300);
    boot(32'h00000100, 1'b1);
    sr_chk("no tbit", CMR_SR_COMBINED, 32'h0);
    pipe_adv = 1'b1;
    for (int i = 0; i < 10 && hard_fault !== 1'b1; i++) tick();
    check("tbit fault", 32'(hard_fault), 32'h1);
    complete_run();
  end
endmodule
